// ---- hw/pvaf_pkg.sv ----
// =====================================================================
// Shared constants of the process value alarm filter
// =====================================================================
package pvaf_pkg;
    // Data widths
    localparam int DATA_W   = 16;              // Converted sample / process value
    localparam int SUM_W    = 24;              // Running sum of up to 128 samples
    localparam int ROC_W    = 17;              // Rate-of-change difference
    localparam int CMP_W    = 18;              // Alarm comparison width, limit +/- hysteresis
    localparam int FILL_W   = 8;               // Sample count, up to 128

    // Averaging depth
    localparam int AVG_DEPTH    = 128;         // Extended variant maximum
    localparam int AVG_AW       = 7;
    localparam logic [7:0] AVG_STD_MAX = 8'h10;  // Standard variant maximum, 16
    localparam logic [7:0] AVG_FIXED   = 8'h04;  // Power transducer variant, always 4

    // Rate-of-change history, 1 to 16 intervals
    localparam int ROC_DEPTH = 16;
    localparam int ROC_AW    = 4;

    // Alarm delays in seconds, 0 to 60
    localparam int DLY_W = 6;
    localparam logic [DLY_W-1:0] DLY_MAX = 6'h3C;

    // Alarm slot positions
    localparam int ALM_NUM       = 6;
    localparam int ALM_UPPER_EXT = 0;
    localparam int ALM_HIGH      = 1;
    localparam int ALM_LOW       = 2;
    localparam int ALM_LOWER_EXT = 3;
    localparam int ALM_ROC_HIGH  = 4;
    localparam int ALM_ROC_LOW   = 5;

    // Timing: one-second tick from the 40 ns core clock
    localparam int TICK_NS     = 1000000000;
    localparam int CLK_NS      = 40;
    localparam int TICK_CYCLES = TICK_NS / CLK_NS;
    localparam int TCNT_W      = 25;

    // Reset values
    localparam logic [DATA_W-1:0] PV_RST  = 16'h0000;
    localparam logic [ROC_W-1:0]  ROC_RST = 17'h00000;
endpackage

// ---- hw/pvaf_alm_if.sv ----
`timescale 1ns/1ps
// =====================================================================
// Settings shared by all alarms of one input
// =====================================================================
interface pvaf_alm_if;
    logic                           tick;      // One-second tick
    logic [pvaf_pkg::DATA_W-1:0]    hyst;      // Hysteresis amount
    logic [pvaf_pkg::DLY_W-1:0]     on_dly;    // ON delay, seconds
    logic [pvaf_pkg::DLY_W-1:0]     off_dly;   // OFF delay, seconds
    modport src (output tick, output hyst, output on_dly, output off_dly);
    modport dst (input tick, input hyst, input on_dly, input off_dly);
endinterface // pvaf_alm_if

// ---- hw/pvaf_alarm.sv ----
`timescale 1ns/1ps
// =====================================================================
// One limit alarm: hysteresis, ON delay and OFF delay
// =====================================================================
module pvaf_alarm (
    // Clock, reset, enable
    input  wire logic                              i_clk,
    input  wire logic                              i_nrst,
    input  wire logic                              i_ce,
    // Shared settings
    pvaf_alm_if.dst                                cfg,
    // Limit and value
    input  wire logic                              i_en,
    input  wire logic                              i_is_high,
    input  wire logic signed [pvaf_pkg::CMP_W-1:0] i_value,
    input  wire logic signed [pvaf_pkg::CMP_W-1:0] i_limit,
    // Result
    output logic                                   o_alarm
);
    typedef enum logic [1:0] {ST_IDLE, ST_ON_WAIT, ST_ACTIVE, ST_OFF_WAIT} pvaf_alm_e;

    pvaf_alm_e                      state_r, state_nxt;
    logic                           cond_r, cond_nxt;
    logic [pvaf_pkg::DLY_W-1:0]     cnt_r, cnt_nxt;
    logic                           alarm_nxt;
    logic                           trip, clear;
    logic signed [pvaf_pkg::CMP_W-1:0] hyst_x;

    // =================================================================
    // Condition with hysteresis
    // =================================================================
    // Set beyond the limit, release only a full hysteresis back inside
    always_comb begin
        hyst_x = $signed({2'b00, cfg.hyst});
        trip   = i_is_high ? (i_value > i_limit) : (i_value < i_limit);  // RULE_03
        clear  = i_is_high ? (i_value <= i_limit - hyst_x)
                           : (i_value >= i_limit + hyst_x);              // RULE_15 RULE_06
        cond_nxt = i_en & (cond_r ? !clear : trip);
    end

    // =================================================================
    // Delay sequencer
    // =================================================================
    // Delays count whole ticks, so a delay of d s lasts d-1 to d s
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        case (state_r)
            ST_IDLE: begin
                if (cond_nxt) begin
                    cnt_nxt   = '0;
                    state_nxt = (cfg.on_dly == '0) ? ST_ACTIVE : ST_ON_WAIT;  // RULE_07
                end
            end
            ST_ON_WAIT: begin
                if (!cond_nxt) begin
                    state_nxt = ST_IDLE;
                end else if (cfg.tick) begin
                    cnt_nxt = cnt_r + 6'h01;
                    if (cnt_nxt >= cfg.on_dly) begin
                        state_nxt = ST_ACTIVE;                            // RULE_07
                    end
                end
            end
            ST_ACTIVE: begin
                if (!cond_nxt) begin
                    cnt_nxt   = '0;
                    state_nxt = (cfg.off_dly == '0) ? ST_IDLE : ST_OFF_WAIT;  // RULE_09
                end
            end
            ST_OFF_WAIT: begin
                if (cond_nxt) begin
                    state_nxt = ST_ACTIVE;
                end else if (cfg.tick) begin
                    cnt_nxt = cnt_r + 6'h01;
                    if (cnt_nxt >= cfg.off_dly) begin
                        state_nxt = ST_IDLE;                              // RULE_09
                    end
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
        alarm_nxt = (state_nxt == ST_ACTIVE) || (state_nxt == ST_OFF_WAIT);
    end

    // Register stage, frozen while the clock enable is low
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_r <= ST_IDLE;
            cond_r  <= 1'b0;
            cnt_r   <= '0;
            o_alarm <= 1'b0;
        end else if (i_ce) begin
            state_r <= state_nxt;
            cond_r  <= cond_nxt;
            cnt_r   <= cnt_nxt;
            o_alarm <= alarm_nxt;
        end
    end

    // =================================================================
    // Checks
    // =================================================================
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    a_on_immediate: assert property (i_ce && state_r == ST_IDLE && cond_nxt          // RULE_07
        && cfg.on_dly == '0 |=> o_alarm) else $error("zero ON delay did not raise alarm");
    a_on_holdoff: assert property (i_ce && state_r == ST_IDLE && cond_nxt            // RULE_07
        && cfg.on_dly != '0 |=> !o_alarm) else $error("alarm raised before ON delay");
    a_off_hold: assert property (i_ce && state_r == ST_ACTIVE && !cond_nxt           // RULE_09
        && cfg.off_dly != '0 |=> o_alarm) else $error("alarm dropped before OFF delay");
    a_hyst_keep: assert property (i_ce && i_en && cond_r && !clear                   // RULE_15
        |=> cond_r) else $error("condition released inside hysteresis band");
endmodule // pvaf_alarm

// ---- hw/pvaf_top.sv ----
`timescale 1ns/1ps
// Functional notes
// RULE_01 - Rate of change formed every second
// RULE_02 - Comparison interval one to sixteen seconds
// RULE_03 - Alarm when rate passes high/low limit
// RULE_04 - Universal variant: rate per conversion period
// RULE_05 - Per-period interval is 1-16 conversion periods
// RULE_06 - One hysteresis for value and rate alarms
// RULE_07 - ON delay 0 to 60 seconds
// RULE_08 - One ON delay shared by six alarms
// RULE_09 - OFF delay 0 to 60 seconds
// RULE_10 - One OFF delay shared by six alarms
// RULE_11 - Moving average of 1 to 16 samples
// RULE_12 - Power transducer variant always averages four
// RULE_13 - Extended variant averages up to 128
// RULE_14 - Two-limit or four-limit process value alarm
// RULE_15 - Alarm clears only past the hysteresis band
// RULE_16 - One-second tick times sampling and delays
module pvaf_top #(
    parameter int TICK_CYCLES = pvaf_pkg::TICK_CYCLES
) (
    // Clock, reset, enable
    input  wire logic                           I_CORE_CLK,
    input  wire logic                           I_NRST,
    input  wire logic                           I_CE,
    // Converted samples
    input  wire logic                           I_SAMPLE_VALID,
    input  wire logic [pvaf_pkg::DATA_W-1:0]    I_SAMPLE,
    // Averaging setup
    input  wire logic [6:0]                     I_AVG_COUNT,
    input  wire logic                           I_AVG_EXT,
    input  wire logic                           I_FIXED_AVG4,
    // Rate-of-change setup
    input  wire logic [3:0]                     I_ROC_INTERVAL,
    input  wire logic                           I_UNIVERSAL,
    input  wire logic                           I_ROC_PER_CONV,
    // Alarm setup
    input  wire logic                           I_FOUR_POINT,
    input  wire logic [pvaf_pkg::DATA_W-1:0]    I_HYST,
    input  wire logic [pvaf_pkg::DLY_W-1:0]     I_ON_DELAY,
    input  wire logic [pvaf_pkg::DLY_W-1:0]     I_OFF_DELAY,
    input  wire logic [pvaf_pkg::DATA_W-1:0]    I_UPPER_EXTREME_LIMIT,
    input  wire logic [pvaf_pkg::DATA_W-1:0]    I_HIGH_LIMIT,
    input  wire logic [pvaf_pkg::DATA_W-1:0]    I_LOW_LIMIT,
    input  wire logic [pvaf_pkg::DATA_W-1:0]    I_LOWER_EXTREME_LIMIT,
    input  wire logic [pvaf_pkg::DATA_W-1:0]    I_ROC_HIGH_LIMIT,
    input  wire logic [pvaf_pkg::DATA_W-1:0]    I_ROC_LOW_LIMIT,
    // Results
    output logic                                O_PV_VALID,
    output logic [pvaf_pkg::DATA_W-1:0]         O_PV,
    output logic                                O_ROC_VALID,
    output logic [pvaf_pkg::ROC_W-1:0]          O_ROC,
    output logic [3:0]                          O_ALM_PV,
    output logic [1:0]                          O_ALM_ROC
);
    localparam int DW = pvaf_pkg::DATA_W;

    // =================================================================
    // One-second tick
    // =================================================================
    logic [pvaf_pkg::TCNT_W-1:0] tcnt_r, tcnt_nxt;
    logic                        tick_r, tick_nxt;

    // Free-running divider; the tick is a one-cycle pulse
    always_comb begin
        tick_nxt = (tcnt_r == pvaf_pkg::TCNT_W'(TICK_CYCLES - 1));        // RULE_16
        tcnt_nxt = tick_nxt ? '0 : tcnt_r + 25'h0000001;
    end

    always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            tcnt_r <= '0;
            tick_r <= 1'b0;
        end else if (I_CE) begin
            tcnt_r <= tcnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    // =================================================================
    // Moving average
    // =================================================================
    logic [DW-1:0]                 avg_mem [pvaf_pkg::AVG_DEPTH];
    logic [pvaf_pkg::AVG_AW-1:0]   awr_r, awr_nxt;
    logic [pvaf_pkg::FILL_W-1:0]   fill_r, fill_nxt, n_r, n_eff;
    logic signed [pvaf_pkg::SUM_W-1:0] sum_r, sum_nxt, quot;
    logic signed [pvaf_pkg::SUM_W-1:0] new_x, old_x;
    logic [DW-1:0]                 pv_nxt;

    // Effective count: fixed four, else 1..16, or 1..128 when extended
    always_comb begin
        n_eff = {1'b0, I_AVG_COUNT} + 8'h01;
        if (I_FIXED_AVG4) begin
            n_eff = pvaf_pkg::AVG_FIXED;                                  // RULE_12
        end else if (!I_AVG_EXT && n_eff > pvaf_pkg::AVG_STD_MAX) begin
            n_eff = pvaf_pkg::AVG_STD_MAX;                                // RULE_11
        end                                                               // RULE_13
    end

    // Running sum; the oldest sample is subtracted once the window is full.
    // A count change restarts the window rather than averaging stale data.
    always_comb begin
        new_x    = pvaf_pkg::SUM_W'($signed(I_SAMPLE));
        old_x    = pvaf_pkg::SUM_W'($signed(avg_mem[awr_r - n_eff[6:0]]));
        sum_nxt  = sum_r;
        fill_nxt = fill_r;
        awr_nxt  = awr_r;
        if (I_SAMPLE_VALID) begin
            awr_nxt = awr_r + 7'h01;
            if (n_eff != n_r) begin
                sum_nxt  = new_x;
                fill_nxt = 8'h01;
            end else if (fill_r < n_eff) begin
                sum_nxt  = sum_r + new_x;
                fill_nxt = fill_r + 8'h01;
            end else begin
                sum_nxt  = sum_r + new_x - old_x;                         // RULE_11
            end
        end
        quot   = sum_nxt / $signed({16'h0000, fill_nxt});
        pv_nxt = quot[DW-1:0];
    end

    always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            awr_r      <= '0;
            fill_r     <= '0;
            n_r        <= '0;
            sum_r      <= '0;
            O_PV       <= pvaf_pkg::PV_RST;
            O_PV_VALID <= 1'b0;
        end else if (I_CE) begin
            awr_r      <= awr_nxt;
            fill_r     <= fill_nxt;
            sum_r      <= sum_nxt;
            O_PV_VALID <= I_SAMPLE_VALID;
            if (I_SAMPLE_VALID) begin
                n_r  <= n_eff;
                O_PV <= pv_nxt;
            end
        end
    end

    // Sample history, no reset: only filled slots are ever read
    always_ff @(posedge I_CORE_CLK) begin
        if (I_CE && I_SAMPLE_VALID) begin
            avg_mem[awr_r] <= I_SAMPLE;
        end
    end

    // =================================================================
    // Rate of change
    // =================================================================
    logic [DW-1:0]               roc_mem [pvaf_pkg::ROC_DEPTH];
    logic [pvaf_pkg::ROC_AW-1:0] rwr_r, rwr_nxt;
    logic [4:0]                  rfill_r, rfill_nxt, intv;
    logic                        per_conv, roc_tick;
    logic [DW-1:0]               roc_old;
    logic [pvaf_pkg::ROC_W-1:0]  roc_nxt;

    // Per-period mode only on the universal variant; the interval then
    // counts conversion periods, e.g. 60-960 ms at a 60 ms period
    always_comb begin
        per_conv  = I_UNIVERSAL & I_ROC_PER_CONV;                          // RULE_04
        roc_tick  = per_conv ? O_PV_VALID : tick_r;                       // RULE_01 RULE_05
        intv      = {1'b0, I_ROC_INTERVAL} + 5'h01;                       // RULE_02
        roc_old   = roc_mem[rwr_r - I_ROC_INTERVAL - 4'h1];
        rwr_nxt   = rwr_r;
        rfill_nxt = rfill_r;
        roc_nxt   = O_ROC;
        if (roc_tick) begin
            rwr_nxt = rwr_r + 4'h1;
            if (rfill_r < 5'h10) begin
                rfill_nxt = rfill_r + 5'h01;
            end
            // Difference every step against the sample one interval back
            roc_nxt = (rfill_r >= intv) ?
                {O_PV[DW-1], O_PV} - {roc_old[DW-1], roc_old} : '0;   // RULE_01
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            rwr_r       <= '0;
            rfill_r     <= '0;
            O_ROC       <= pvaf_pkg::ROC_RST;
            O_ROC_VALID <= 1'b0;
        end else if (I_CE) begin
            rwr_r       <= rwr_nxt;
            rfill_r     <= rfill_nxt;
            O_ROC       <= roc_nxt;
            O_ROC_VALID <= roc_tick;
        end
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (I_CE && roc_tick) begin
            roc_mem[rwr_r] <= O_PV;
        end
    end

    // =================================================================
    // Alarms
    // =================================================================
    pvaf_alm_if alm_cfg ();
    logic signed [pvaf_pkg::CMP_W-1:0] alm_val [pvaf_pkg::ALM_NUM];
    logic signed [pvaf_pkg::CMP_W-1:0] alm_lim [pvaf_pkg::ALM_NUM];
    logic [pvaf_pkg::ALM_NUM-1:0]      alm_en, alm_q;

    // One hysteresis and one pair of delays for all six alarms
    assign alm_cfg.tick    = tick_r;                                      // RULE_16
    assign alm_cfg.hyst    = I_HYST;                                      // RULE_06
    assign alm_cfg.on_dly  = (I_ON_DELAY > pvaf_pkg::DLY_MAX) ?
                             pvaf_pkg::DLY_MAX : I_ON_DELAY;              // RULE_08
    assign alm_cfg.off_dly = (I_OFF_DELAY > pvaf_pkg::DLY_MAX) ?
                             pvaf_pkg::DLY_MAX : I_OFF_DELAY;             // RULE_10

    // Extreme limits only take part in four-limit mode
    always_comb begin
        for (int k = 0; k < pvaf_pkg::ALM_ROC_HIGH; k++) begin
            alm_val[k] = pvaf_pkg::CMP_W'($signed(O_PV));
        end
        alm_val[pvaf_pkg::ALM_ROC_HIGH] = pvaf_pkg::CMP_W'($signed(O_ROC));
        alm_val[pvaf_pkg::ALM_ROC_LOW]  = pvaf_pkg::CMP_W'($signed(O_ROC));
        alm_lim[pvaf_pkg::ALM_UPPER_EXT] = pvaf_pkg::CMP_W'($signed(I_UPPER_EXTREME_LIMIT));
        alm_lim[pvaf_pkg::ALM_HIGH]      = pvaf_pkg::CMP_W'($signed(I_HIGH_LIMIT));
        alm_lim[pvaf_pkg::ALM_LOW]       = pvaf_pkg::CMP_W'($signed(I_LOW_LIMIT));
        alm_lim[pvaf_pkg::ALM_LOWER_EXT] = pvaf_pkg::CMP_W'($signed(I_LOWER_EXTREME_LIMIT));
        alm_lim[pvaf_pkg::ALM_ROC_HIGH]  = pvaf_pkg::CMP_W'($signed(I_ROC_HIGH_LIMIT));
        alm_lim[pvaf_pkg::ALM_ROC_LOW]   = pvaf_pkg::CMP_W'($signed(I_ROC_LOW_LIMIT));
        alm_en = {2'h3, I_FOUR_POINT, 2'h3, I_FOUR_POINT};                // RULE_14
    end

    for (genvar g = 0; g < pvaf_pkg::ALM_NUM; g++) begin : g_alm
        pvaf_alarm u_alarm (
            .i_clk     (I_CORE_CLK),
            .i_nrst    (I_NRST),
            .i_ce      (I_CE),
            .cfg       (alm_cfg),
            .i_en      (alm_en[g]),
            .i_is_high ((g == 0) || (g == 1) || (g == 4)),
            .i_value   (alm_val[g]),
            .i_limit   (alm_lim[g]),
            .o_alarm   (alm_q[g])
        );
    end

    // Flop outputs of the alarm cells, passed through unchanged
    assign O_ALM_PV  = alm_q[3:0];
    assign O_ALM_ROC = alm_q[5:4];                                        // RULE_03

    // =================================================================
    // Checks
    // =================================================================
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_NRST);

    a_tick_wrap: assert property (I_CE && tick_r |-> tcnt_r == '0)        // RULE_16
        else $error("tick not aligned to divider wrap");
    a_avg_fixed: assert property (I_FIXED_AVG4 |-> n_eff == 8'h04)        // RULE_12
        else $error("fixed averaging count is not four");
    a_avg_clamp: assert property (!I_FIXED_AVG4 && !I_AVG_EXT |-> n_eff <= 8'h10) // RULE_11
        else $error("standard averaging count above sixteen");
    a_roc_second: assert property (I_CE && !per_conv && tick_r |=> O_ROC_VALID) // RULE_01
        else $error("rate of change not formed on second tick");
    a_roc_mode: assert property (I_CE && O_ROC_VALID && !$past(per_conv) // RULE_04
        |-> $past(tick_r)) else $error("rate step outside second tick");
    a_pv_update: assert property (I_CE && I_SAMPLE_VALID |=> O_PV_VALID) // RULE_11
        else $error("process value not updated after sample");
endmodule // pvaf_top

// ---- verification/pvaf_src.sv ----
`timescale 1ns/1ps
// =====================================================================
// Conversion front end: one sample pulse per conversion period
// =====================================================================
module pvaf_src (
    // Clock
    input  wire logic        i_clk,
    // Sample stream
    output logic             o_valid,
    output logic [15:0]      o_sample
);
    initial begin
        o_valid  = 1'b0;
        o_sample = 16'h0000;
    end
    // One-cycle pulse; the data line is not held afterwards, so stale reuse shows
    task automatic send(input logic [15:0] v);
        @(posedge i_clk);
        o_valid  <= 1'b1;
        o_sample <= v;
        @(posedge i_clk);
        o_valid  <= 1'b0;
        o_sample <= ~v;
    endtask
endmodule // pvaf_src

// ---- verification/pvaf_top_tb_top.sv ----
`timescale 1ns/1ps
// =====================================================================
// Bench for the process value alarm filter
// =====================================================================
module pvaf_top_tb_top;
    localparam int TK = 20;    // Short tick for simulation
    logic clk = 1'b0, nrst = 1'b0, sv, ext = 1'b0, fix = 1'b0, per = 1'b1;
    logic [15:0] smp, pv, hy = 16'h000A, hl = 16'h00C8, rh = 16'h0014;
    logic ce = 1'b1, fp = 1'b1;
    logic [3:0] riv = 4'h0;
    logic [6:0] avgc = 7'h00;
    logic [5:0] ond = 6'h00, offd = 6'h00;
    logic pvv, rv;
    logic [16:0] roc;
    logic [3:0] apv;
    logic [1:0] arc;
    int n_errors = 0, num_checks = 0, k;
    logic [15:0] tab [5] = '{16'h0004, 16'h0008, 16'h000C, 16'h0010, 16'h0014};
    always #20 clk = ~clk;
    pvaf_src i_pvaf_src (.i_clk(clk), .o_valid(sv), .o_sample(smp));
    pvaf_top #(.TICK_CYCLES(TK)) i_pvaf_top (
        .I_CORE_CLK(clk), .I_NRST(nrst), .I_CE(ce), .I_SAMPLE_VALID(sv),
        .I_SAMPLE(smp), .I_AVG_COUNT(avgc), .I_AVG_EXT(ext), .I_FIXED_AVG4(fix),
        .I_ROC_INTERVAL(riv), .I_UNIVERSAL(1'b1), .I_ROC_PER_CONV(per),
        .I_FOUR_POINT(fp), .I_HYST(hy), .I_ON_DELAY(ond), .I_OFF_DELAY(offd),
        .I_UPPER_EXTREME_LIMIT(16'h00FA), .I_HIGH_LIMIT(hl), .I_LOW_LIMIT(16'h8000),
        .I_LOWER_EXTREME_LIMIT(16'h8000), .I_ROC_HIGH_LIMIT(rh),
        .I_ROC_LOW_LIMIT(16'hFC18), .O_PV_VALID(pvv), .O_PV(pv), .O_ROC_VALID(rv),
        .O_ROC(roc), .O_ALM_PV(apv), .O_ALM_ROC(arc));
    // Compare and count
    task automatic chk(input string nm, input logic [16:0] seen, input logic [16:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    function automatic logic sel(input int w);
        case (w)
            0: sel = pvv;
            1: sel = rv;
            2: sel = apv[1];
            default: sel = ~apv[1];
        endcase
    endfunction
    // Bounded wait, entered just after an edge
    task automatic wait_for(input int w, input int lim);
        repeat (lim) begin
            if (sel(w) === 1'b1) break;
            @(posedge clk);
            #1;
        end
    endtask
    task automatic put(input logic [15:0] v);
        i_pvaf_src.send(v);
        #1;
        wait_for(0, 4);
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Watchdog: the sequence needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        print_verdict();
    end
    // Rate steps per conversion period, then hysteresis on the rate alarm
    task automatic rate_put(input logic [15:0] v, input logic [16:0] er, input logic ea);
        put(v);
        wait_for(1, 4);
        chk("roc", roc, er);
        repeat (4) @(posedge clk);
        #1;
        chk("roc_alarm", {16'h0000, arc[0]}, {16'h0000, ea});
    endtask
    initial begin
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        put(16'h000A);
        put(16'h001E);
        rate_put(16'h0046, 17'h00028, 1'b1);
        rate_put(16'h0055, 17'h0000F, 1'b1);
        rate_put(16'h005A, 17'h00005, 1'b0);
        $display("rate test done");
        // Value alarm held back by ON delay, kept by OFF delay
        @(posedge clk);
        ond <= 6'h02;
        put(16'h012C);
        repeat (5) @(posedge clk);
        #1;
        chk("on_wait", {16'h0000, apv[1]}, 17'h00000);
        wait_for(2, 4 * TK);
        chk("on_set", {16'h0000, apv[1]}, 17'h00001);
        chk("ext_set", {16'h0000, apv[0]}, 17'h00001);
        // Two-limit mode forces the extreme alarm off, the high alarm stays
        @(posedge clk);
        fp <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk("ext_off", {16'h0000, apv[0]}, 17'h00000);
        chk("high_kept", {16'h0000, apv[1]}, 17'h00001);
        @(posedge clk);
        fp   <= 1'b1;
        offd <= 6'h02;
        put(16'h0064);
        repeat (5) @(posedge clk);
        #1;
        chk("off_wait", {16'h0000, apv[1]}, 17'h00001);
        wait_for(3, 4 * TK);
        chk("off_clr", {16'h0000, apv[1]}, 17'h00000);
        $display("delay test done");
        // Fixed four-sample average, then an extended depth of eight
        for (int p = 0; p < 2; p++) begin
            @(posedge clk);
            fix  <= (p == 0);
            ext  <= (p == 1);
            avgc <= (p == 0) ? 7'h00 : 7'h07;
            for (int i = 0; i < 5; i++) begin
                k = (p == 0) ? 4 : 8;
                put(tab[i]);
                k = (i + 1 < k) ? i + 1 : k;
                chk("pv", {1'b0, pv}, 17'((4 * (2 * i - k + 3) * k / 2) / k));
            end
        end
        $display("average test done");
        // Once-a-second rate step with a steady value
        @(posedge clk);
        per <= 1'b0;
        // Let the step of the last sample pass before timing the ticks
        repeat (2) @(posedge clk);
        #1;
        wait_for(1, 3 * TK);
        @(posedge clk);
        #1;
        k = 1;
        while (rv !== 1'b1 && k < 3 * TK) begin
            @(posedge clk);
            #1;
            k++;
        end
        chk("tick_gap", 17'(k), 17'(TK));
        chk("roc_hold", roc, 17'h00000);
        $display("tick test done");
        // Interval of two steps, then a sample sent while the enable is low
        @(posedge clk);
        per  <= 1'b1;
        riv  <= 4'h1;
        avgc <= 7'h00;
        ext  <= 1'b0;
        rate_put(16'h0030, 17'h00024, 1'b0);
        rate_put(16'h0040, 17'h00034, 1'b0);
        @(posedge clk);
        ce <= 1'b0;
        i_pvaf_src.send(16'h0100);
        @(posedge clk);
        ce <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk("ce_hold", {1'b0, pv}, 17'h00040);
        $display("interval and enable test done");
        print_verdict();
    end
endmodule // pvaf_top_tb_top
